// ---- hdl/pcs_defines.svh ----
// Offsets, field positions and reset values of the program counter and return stack unit.
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
`define PCS_OFF_STATUS_FLAGS_SHADOW 12'hfe4
`define PCS_OFF_WORK_SHAD 12'hfe5
`define PCS_OFF_BANK_SHAD 12'hfe6
`define PCS_OFF_LATCH_SHAD 12'hfe7
`define PCS_OFF_P0L_SHAD 12'hfe8
`define PCS_OFF_P0H_SHAD 12'hfe9
`define PCS_OFF_P1L_SHAD 12'hfea
`define PCS_OFF_P1H_SHAD 12'hfeb
`define PCS_OFF_INDEX 12'hfed
`define PCS_OFF_TOP_LOW 12'hfee
`define PCS_OFF_TOP_HIGH 12'hfef
`define PCS_OFF_CTRL 12'hfe0
`define PCS_OFF_PC_LOW 12'hfe1
`define PCS_OFF_PC_LATCH 12'hfe2
`define PCS_IDX_RESET 5'h1f
`define PCS_IDX_TOP 5'h0f
`define PCS_IDX_EMPTY 5'h1f
`define PCS_IDX_ONE 5'h01
`define PCS_PC_ONE 15'h0001
`define PCS_PC_RESET 15'h0000
`define PCS_BYTE_RESET 8'h00
`define PCS_STATUS_MASK 8'h07
`define PCS_BANK_MASK 8'h1f
`define PCS_HIGH_MASK 8'h7f
`define PCS_CTRL_FAULT_EN 0
`define PCS_CTRL_OVF 1
`define PCS_CTRL_UNF 2
`endif

// ---- hdl/pcs_pkg.sv ----
// Types shared by the program counter and return stack unit.
package pcs_pkg;
  typedef enum logic [3:0] {
    pcs_op_none = 4'h0,
    pcs_op_seq = 4'h1,
    pcs_op_call = 4'h2,
    pcs_op_computed_call_op = 4'h3,
    pcs_op_brw = 4'h4,
    pcs_op_bra = 4'h5,
    pcs_op_ret = 4'h6,
    pcs_op_return_with_literal_op = 4'h7,
    pcs_op_return_from_interrupt_op = 4'h8,
    pcs_op_vector = 4'h9,
    pcs_op_pcl_write = 4'ha
  } pcs_op_t;

  typedef struct packed {
    pcs_op_t op;
    logic [10:0] operand;
    logic [14:0] vector;
    logic [7:0] work;
    logic [7:0] pcl_data;
  } pcs_cmd_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] work;
    logic [7:0] bank;
    logic [7:0] latch;
    logic [7:0] p0l;
    logic [7:0] p0h;
    logic [7:0] p1l;
    logic [7:0] p1h;
  } pcs_ctx_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pcs_wb_req_t;

  typedef enum logic [1:0] {
    pcs_st_idle = 2'b00,
    pcs_st_ack = 2'b01
  } pcs_bus_st_t;
endpackage

// ---- hdl/pcs_stack_mem.sv ----
// Sixteen-entry by 15-bit return stack storage with one write and one read port.
`timescale 1ns/1ns
module pcs_stack_mem (
  input wire logic clock, // Core clock.
  input wire logic we, // Write strobe.
  input wire logic [3:0] waddr, // Write entry.
  input wire logic [14:0] wdata, // Write value.
  input wire logic [3:0] raddr, // Read entry.
  output logic [14:0] rdata // Read value, combinational.
);
  logic [14:0] mem [16];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule // pcs_stack_mem

// ---- hdl/pcs_top.sv ----
// Program counter sequencing, return stack and context shadows with a Wishbone slave.
//
// Overview of operation
// - 15-bit counter; low byte register, upper seven bits from the upper latch.
// - Every reset clears the whole program counter.
// - Writing the low byte also loads the upper bits from the latch.
// - Direct call: low byte and bits 10:8 from operand, 14:11 from latch.
// - Computed call: low byte from working value, upper part from latch.
// - Branch by working value: incremented address plus unsigned working value.
// - Relative branch: incremented address plus signed operand bits 8:0.
// - Sixteen entry, fifteen bit stack outside program and data spaces.
// - Calls and vectoring push; returns pop.
// - Push and pop leave the upper latch unchanged.
// - With fault reset disabled the stack wraps circularly.
// - Overflow and underflow flags set whether or not fault reset enabled.
// - Stack index selects the entry the top-of-stack window accesses.
// - Stack index is five bits wide to detect overflow and underflow.
// - Push increments then stores; pop reads then decrements.
// - Top-of-stack is a readable, writable high and low register pair.
// - Shadows exist for both pointer pairs, working, bank and latch.
// - With fault reset enabled, overflow or underflow requests reset and sets flag.
`timescale 1ns/1ns
`include "pcs_defines.svh"
module pcs_top (
  input wire logic clock, // Core clock, 50 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire pcs_pkg::pcs_cmd_t cmd, // Sequencing command from decode.
  input wire pcs_pkg::pcs_ctx_t ctx_in, // Live context to save on vectoring.
  input wire logic [7:0] latch_in, // Live upper latch value from the core.
  input wire pcs_pkg::pcs_wb_req_t wb_req, // Wishbone request.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  output logic [14:0] pc, // Program counter, fetch address.
  output pcs_pkg::pcs_ctx_t ctx_restore, // Shadow context for restoring.
  output logic ctx_restore_valid, // One-cycle pulse on interrupt return.
  output logic fault_reset_req // One-cycle stack fault reset request.
);
  import pcs_pkg::*;

  logic [14:0] pc_q;
  logic [14:0] pc_d;
  logic [4:0] idx_q;
  logic [7:0] latch_q;
  logic fault_en_q;
  logic ovf_q;
  logic unf_q;
  pcs_ctx_t shad_q;
  logic restore_q;
  logic fault_q;
  logic [31:0] rdat_q;
  logic ack_q;
  logic [14:0] stk_rdata;
  logic [14:0] stk_wdata;
  logic [3:0] stk_waddr;
  logic stk_we;
  logic [4:0] idx_inc;
  logic [4:0] idx_dec;
  logic is_push;
  logic is_pop;
  logic push_ovf;
  logic pop_unf;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_byte;
  logic [14:0] pc_inc;
  logic [14:0] stk_top;

  assign pc_inc = pc_q + `PCS_PC_ONE;
  assign idx_inc = idx_q + `PCS_IDX_ONE;
  assign idx_dec = idx_q - `PCS_IDX_ONE;
  assign is_push = (cmd.op == pcs_op_call) || (cmd.op == pcs_op_computed_call_op) ||
                   (cmd.op == pcs_op_vector);
  assign is_pop = (cmd.op == pcs_op_ret) || (cmd.op == pcs_op_return_with_literal_op) ||
                  (cmd.op == pcs_op_return_from_interrupt_op);
  // Full and empty detection on the five-bit index.
  assign push_ovf = is_push && (idx_q == `PCS_IDX_TOP);
  assign pop_unf = is_pop && (idx_q == `PCS_IDX_EMPTY);

  assign bus_req = wb_req.cyc && wb_req.stb && !ack_q;
  // A write lands at the edge where the master sees ack, not at the taking edge.
  assign bus_wr = wb_req.cyc && wb_req.stb && ack_q && wb_req.we && wb_req.sel[0];
  assign bus_rd = bus_req && !wb_req.we;
  assign bus_byte = wb_req.dat[7:0];

  // Push stores at the incremented index; the window follows the index.
  always_comb begin
    stk_we = 1'b0;
    stk_waddr = idx_inc[3:0];
    stk_wdata = pc_inc;
    if (is_push) begin
      stk_we = 1'b1;
    end else if (bus_wr && wb_req.adr == `PCS_OFF_TOP_LOW) begin
      // Low byte write into selected entry.
      stk_we = 1'b1;
      stk_waddr = idx_q[3:0];
      stk_wdata = {stk_rdata[14:8], bus_byte};
    end else if (bus_wr && wb_req.adr == `PCS_OFF_TOP_HIGH) begin
      stk_we = 1'b1;
      stk_waddr = idx_q[3:0];
      stk_wdata = {bus_byte[6:0], stk_rdata[7:0]};
    end
  end

  // Window reads the entry the index selects.
  pcs_stack_mem u_mem (
    .clock(clock),
    .we(stk_we),
    .waddr(stk_waddr),
    .wdata(stk_wdata),
    .raddr(idx_q[3:0]),
    .rdata(stk_rdata)
  );
  assign stk_top = stk_rdata;

  always_comb begin
    pc_d = pc_q;
    case (cmd.op)
      pcs_op_seq: pc_d = pc_inc;
      pcs_op_call: pc_d = {latch_q[6:3], cmd.operand};
      pcs_op_computed_call_op: pc_d = {latch_q[6:0], cmd.work};
      pcs_op_brw: pc_d = pc_inc + {7'h00, cmd.work};
      pcs_op_bra: pc_d = pc_inc + {{6{cmd.operand[8]}}, cmd.operand[8:0]};
      // Pop reads the entry before the index moves.
      pcs_op_ret, pcs_op_return_with_literal_op, pcs_op_return_from_interrupt_op: pc_d = stk_top;
      pcs_op_vector: pc_d = cmd.vector;
      // Low byte write loads upper bits from the latch together.
      pcs_op_pcl_write: pc_d = {latch_q[6:0], cmd.pcl_data};
      default: pc_d = pc_q;
    endcase
    if (bus_wr && wb_req.adr == `PCS_OFF_PC_LOW) begin
      pc_d = {latch_q[6:0], bus_byte};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pc_q <= `PCS_PC_RESET;
    end else begin
      // A fault restarts the counter as a reset would.
      if (fault_en_q && (push_ovf || pop_unf)) begin
        pc_q <= `PCS_PC_RESET;
      end else begin
        pc_q <= pc_d;
      end
    end
  end

  // Latch follows only the core and the bus, never the stack.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      latch_q <= `PCS_BYTE_RESET;
    end else if (bus_wr && wb_req.adr == `PCS_OFF_PC_LATCH) begin
      latch_q <= bus_byte & `PCS_HIGH_MASK;
    end else begin
      latch_q <= latch_in & `PCS_HIGH_MASK;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      idx_q <= `PCS_IDX_RESET;
    end else if (fault_en_q && (push_ovf || pop_unf)) begin
      idx_q <= `PCS_IDX_RESET;
    end else if (is_push) begin
      // Wraps through the four-bit entry address.
      idx_q <= {1'b0, idx_inc[3:0]};
    end else if (is_pop) begin
      idx_q <= (idx_q == `PCS_IDX_EMPTY) ? `PCS_IDX_TOP : idx_dec;
    end else if (bus_wr && wb_req.adr == `PCS_OFF_INDEX) begin
      idx_q <= bus_byte[4:0];
    end
  end

  // Sticky flags; a new event wins over a software clear.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      fault_en_q <= 1'b0;
    end else begin
      if (bus_wr && wb_req.adr == `PCS_OFF_CTRL) begin
        fault_en_q <= bus_byte[`PCS_CTRL_FAULT_EN];
      end
      if (push_ovf) begin
        ovf_q <= 1'b1;
      end else if (bus_wr && wb_req.adr == `PCS_OFF_CTRL && bus_byte[`PCS_CTRL_OVF]) begin
        ovf_q <= 1'b0;
      end
      if (pop_unf) begin
        unf_q <= 1'b1;
      end else if (bus_wr && wb_req.adr == `PCS_OFF_CTRL && bus_byte[`PCS_CTRL_UNF]) begin
        unf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_en_q && (push_ovf || pop_unf);
    end
  end

  // Context save on vectoring and bus access to shadows.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shad_q <= '0;
    end else if (cmd.op == pcs_op_vector) begin
      shad_q <= ctx_in;
      shad_q.status <= ctx_in.status & `PCS_STATUS_MASK;
      shad_q.bank <= ctx_in.bank & `PCS_BANK_MASK;
      shad_q.latch <= ctx_in.latch & `PCS_HIGH_MASK;
    end else if (bus_wr) begin
      case (wb_req.adr)
        `PCS_OFF_STATUS_FLAGS_SHADOW: shad_q.status <= bus_byte & `PCS_STATUS_MASK;
        `PCS_OFF_WORK_SHAD: shad_q.work <= bus_byte;
        `PCS_OFF_BANK_SHAD: shad_q.bank <= bus_byte & `PCS_BANK_MASK;
        `PCS_OFF_LATCH_SHAD: shad_q.latch <= bus_byte & `PCS_HIGH_MASK;
        `PCS_OFF_P0L_SHAD: shad_q.p0l <= bus_byte;
        `PCS_OFF_P0H_SHAD: shad_q.p0h <= bus_byte;
        `PCS_OFF_P1L_SHAD: shad_q.p1l <= bus_byte;
        `PCS_OFF_P1H_SHAD: shad_q.p1h <= bus_byte;
        default: shad_q <= shad_q;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      restore_q <= 1'b0;
    end else begin
      restore_q <= (cmd.op == pcs_op_return_from_interrupt_op);
    end
  end

  // Single-wait slave: ack one cycle after the request, dropped the next cycle.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= bus_req;
      if (bus_rd) begin
        case (wb_req.adr)
          `PCS_OFF_STATUS_FLAGS_SHADOW: rdat_q <= {24'h000000, shad_q.status};
          `PCS_OFF_WORK_SHAD: rdat_q <= {24'h000000, shad_q.work};
          `PCS_OFF_BANK_SHAD: rdat_q <= {24'h000000, shad_q.bank};
          `PCS_OFF_LATCH_SHAD: rdat_q <= {24'h000000, shad_q.latch};
          `PCS_OFF_P0L_SHAD: rdat_q <= {24'h000000, shad_q.p0l};
          `PCS_OFF_P0H_SHAD: rdat_q <= {24'h000000, shad_q.p0h};
          `PCS_OFF_P1L_SHAD: rdat_q <= {24'h000000, shad_q.p1l};
          `PCS_OFF_P1H_SHAD: rdat_q <= {24'h000000, shad_q.p1h};
          `PCS_OFF_INDEX: rdat_q <= {27'h0, idx_q};
          `PCS_OFF_TOP_LOW: rdat_q <= {24'h000000, stk_top[7:0]};
          `PCS_OFF_TOP_HIGH: rdat_q <= {25'h0, stk_top[14:8]};
          `PCS_OFF_CTRL: rdat_q <= {29'h0, unf_q, ovf_q, fault_en_q};
          // Only the low byte of the counter is visible.
          `PCS_OFF_PC_LOW: rdat_q <= {24'h000000, pc_q[7:0]};
          `PCS_OFF_PC_LATCH: rdat_q <= {24'h000000, latch_q};
          default: rdat_q <= '0;
        endcase
      end else begin
        rdat_q <= '0;
      end
    end
  end

  assign pc = pc_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign ctx_restore = shad_q;
  assign ctx_restore_valid = restore_q;
  assign fault_reset_req = fault_q;
endmodule // pcs_top

// ---- dv/pcs_props.sv ----
// Port assertions for the program counter and return stack unit.
`timescale 1ns/1ns
module pcs_props (
  input wire logic clock, // Core clock.
  input wire logic nrst, // Reset, active low.
  input wire pcs_pkg::pcs_cmd_t cmd, // Command.
  input wire pcs_pkg::pcs_ctx_t ctx_in, // Live context.
  input wire logic [7:0] latch_in, // Live latch.
  input wire pcs_pkg::pcs_wb_req_t wb_req, // Bus request.
  input wire logic [31:0] wb_dat_o, // Read data.
  input wire logic wb_ack_o, // Acknowledge.
  input wire logic [14:0] pc, // Program counter.
  input wire pcs_pkg::pcs_ctx_t ctx_restore, // Shadows.
  input wire logic ctx_restore_valid, // Restore pulse.
  input wire logic fault_reset_req // Fault pulse.
);
  import pcs_pkg::*;
  logic q;
  // A bus write may override the command, so targets are judged only on a quiet bus.
  assign q = !wb_req.cyc;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_call_target: assert property (q && cmd.op == pcs_op_call && $stable(latch_in)
    |=> fault_reset_req || pc == {$past(latch_in[6:3]), $past(cmd.operand)})
    else $error("call target wrong");
  a_computed_call_op_target: assert property (q && cmd.op == pcs_op_computed_call_op && $stable(latch_in)
    |=> fault_reset_req || pc == {$past(latch_in[6:0]), $past(cmd.work)})
    else $error("computed_call_op target wrong");
  a_pcl_load: assert property (q && cmd.op == pcs_op_pcl_write && $stable(latch_in)
    |=> pc == {$past(latch_in[6:0]), $past(cmd.pcl_data)}) else $error("low byte load wrong");
  a_brw_target: assert property (q && cmd.op == pcs_op_brw
    |=> pc == $past(pc) + 15'h0001 + {7'h00, $past(cmd.work)}) else $error("brw target wrong");
  a_bra_target: assert property (q && cmd.op == pcs_op_bra |=> pc == $past(pc) + 15'h0001
    + {{6{$past(cmd.operand[8])}}, $past(cmd.operand[8:0])}) else $error("bra target wrong");
  a_idle_holds: assert property (q && cmd.op == pcs_op_none |=> $stable(pc))
    else $error("pc moved without command");
  a_ret_returns: assert property (q && cmd.op == pcs_op_call ##1 q && cmd.op == pcs_op_ret
    && !fault_reset_req |=> pc == $past(pc, 2) + 15'h0001) else $error("return address wrong");
  a_fault_clears: assert property (fault_reset_req |-> pc == 15'h0000)
    else $error("fault did not clear pc");
  a_restore_pulse: assert property (ctx_restore_valid == $past(cmd.op == pcs_op_return_from_interrupt_op))
    else $error("restore pulse wrong");
  a_ack_pulse: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
  a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  c_call_ret: cover property (cmd.op == pcs_op_call ##1 cmd.op == pcs_op_ret);
  c_fault: cover property (fault_reset_req);
  c_restore: cover property (ctx_restore_valid);
endmodule // pcs_props
bind pcs_top pcs_props u_props (.clock(clock), .nrst(nrst), .cmd(cmd), .ctx_in(ctx_in),
  .latch_in(latch_in), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pc(pc),
  .ctx_restore(ctx_restore), .ctx_restore_valid(ctx_restore_valid),
  .fault_reset_req(fault_reset_req));

// ---- dv/pcs_decode_model.sv ----
// Decode-side model presenting sequencing commands and live context.
`timescale 1ns/1ns
module pcs_decode_model (
  output pcs_pkg::pcs_cmd_t cmd, // Command to the unit.
  output pcs_pkg::pcs_ctx_t ctx_in, // Live context.
  output logic [7:0] latch_in, // Live upper latch.
  input wire logic clock // Core clock.
);
  import pcs_pkg::*;
  initial begin
    cmd = '0;
    ctx_in = '0;
    latch_in = 8'h00;
  end
  // Callers start right after a rising edge, so each command stands for exactly one edge.
  task automatic issue(input pcs_op_t o, input logic [10:0] a, input logic [7:0] w);
    cmd <= '{op: o, operand: a, vector: 15'h0004, work: w, pcl_data: w};
    @(posedge clock);
  endtask
  task automatic idle();
    cmd.op <= pcs_op_none;
    @(posedge clock);
  endtask
  // The extra edge lets the unit sample the new latch before any command uses it.
  task automatic set_live(input logic [7:0] l, input pcs_ctx_t c);
    latch_in <= l;
    ctx_in <= c;
    repeat (2) @(posedge clock);
  endtask
endmodule // pcs_decode_model

// ---- dv/test_pcs_top.sv ----
// Self-checking bench for the program counter and return stack unit.
`timescale 1ns/1ns
`include "pcs_defines.svh"
`define CMP(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_pcs_top;
  import pcs_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  pcs_cmd_t cmd;
  pcs_ctx_t ctx_in, ctx_restore, ctx_exp;
  logic [7:0] latch_in, rd;
  pcs_wb_req_t wb_req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, ctx_restore_valid, fault_reset_req;
  logic [14:0] pc;
  int n_fail = 0;
  int tests_run = 0;
  always #10 clock = ~clock;
  pcs_decode_model DEC (.cmd(cmd), .ctx_in(ctx_in), .latch_in(latch_in), .clock(clock));
  pcs_top DUT (.clock(clock), .nrst(nrst), .cmd(cmd), .ctx_in(ctx_in), .latch_in(latch_in),
    .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pc(pc),
    .ctx_restore(ctx_restore), .ctx_restore_valid(ctx_restore_valid),
    .fault_reset_req(fault_reset_req));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Released write data is inverted so a stale bus value is never mistaken for a live one.
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h000000, d}};
    // Ack is looked at mid-cycle, where it has settled, and acted on at the next rising edge.
    for (i = 0; i < 20; i++) begin
      @(negedge clock);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o[7:0];
    if (i == 20) begin
      n_fail++;
      print_verdict();
    end
    @(posedge clock);
    wb_req <= '{cyc: 1'b0, stb: 1'b0, we: w, adr: a, sel: 4'h1, dat: ~{24'h000000, d}};
    @(posedge clock);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CMP("register", e, rd)
  endtask
  initial begin
    int k;
    ctx_exp = '{8'h07, 8'h11, 8'h1f, 8'h7f, 8'h22, 8'h33, 8'h44, 8'h55};
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    `CMP("pc", 15'h0000, pc)
    rchk(`PCS_OFF_INDEX, 8'h1f);
    rchk(`PCS_OFF_CTRL, 8'h00);
    $display("reset test done");
    DEC.set_live(8'h55, '{8'hff, 8'h11, 8'hff, 8'hff, 8'h22, 8'h33, 8'h44, 8'h55});
    DEC.issue(pcs_op_pcl_write, 11'h000, 8'h12);
    DEC.idle();
    `CMP("pc", 15'h5512, pc)
    DEC.issue(pcs_op_call, 11'h345, 8'h00);
    DEC.idle();
    `CMP("pc", 15'h5345, pc)
    rchk(`PCS_OFF_INDEX, 8'h00);
    rchk(`PCS_OFF_TOP_LOW, 8'h13);
    rchk(`PCS_OFF_TOP_HIGH, 8'h55);
    rchk(`PCS_OFF_PC_LATCH, 8'h55);
    DEC.issue(pcs_op_ret, 11'h000, 8'h00);
    DEC.issue(pcs_op_brw, 11'h000, 8'hff);
    DEC.issue(pcs_op_bra, 11'h7ff, 8'h00);
    DEC.idle();
    `CMP("pc", 15'h5613, pc)
    DEC.issue(pcs_op_call, 11'h100, 8'h00);
    DEC.issue(pcs_op_ret, 11'h000, 8'h00);
    DEC.issue(pcs_op_computed_call_op, 11'h000, 8'h80);
    DEC.idle();
    `CMP("pc", 15'h5580, pc)
    $display("target test done");
    for (k = 0; k < 16; k++) DEC.issue(pcs_op_call, 11'h100, 8'h00);
    DEC.idle();
    rchk(`PCS_OFF_INDEX, 8'h00);
    rchk(`PCS_OFF_TOP_LOW, 8'h01);
    rchk(`PCS_OFF_CTRL, 8'h02);
    wb(1'b1, `PCS_OFF_CTRL, 8'h02);
    rchk(`PCS_OFF_CTRL, 8'h00);
    $display("wrap test done");
    wb(1'b1, `PCS_OFF_CTRL, 8'h01);
    wb(1'b1, `PCS_OFF_INDEX, 8'h0f);
    DEC.issue(pcs_op_call, 11'h100, 8'h00);
    DEC.idle();
    `CMP("pc", 15'h0000, pc)
    rchk(`PCS_OFF_INDEX, 8'h1f);
    rchk(`PCS_OFF_CTRL, 8'h03);
    DEC.issue(pcs_op_ret, 11'h000, 8'h00);
    DEC.idle();
    rchk(`PCS_OFF_CTRL, 8'h07);
    wb(1'b1, `PCS_OFF_CTRL, 8'h06);
    rchk(`PCS_OFF_CTRL, 8'h00);
    $display("fault test done");
    wb(1'b1, `PCS_OFF_INDEX, 8'h03);
    wb(1'b1, `PCS_OFF_TOP_LOW, 8'hab);
    wb(1'b1, `PCS_OFF_TOP_HIGH, 8'h12);
    rchk(`PCS_OFF_TOP_HIGH, 8'h12);
    // vectoring waits until the index is no longer being moved
    DEC.issue(pcs_op_ret, 11'h000, 8'h00);
    DEC.idle();
    `CMP("pc", 15'h12ab, pc)
    rchk(`PCS_OFF_INDEX, 8'h02);
    DEC.issue(pcs_op_vector, 11'h000, 8'h00);
    DEC.idle();
    `CMP("pc", 15'h0004, pc)
    for (k = 0; k < 8; k++) rchk(12'hfe4 + 12'(k), ctx_exp[63 - 8 * k -: 8]);
    DEC.issue(pcs_op_return_from_interrupt_op, 11'h000, 8'h00);
    DEC.idle();
    `CMP("pc", 15'h12ac, pc)
    `CMP("ctx", ctx_exp, ctx_restore)
    wb(1'b1, 12'hfec, 8'h5a);
    rchk(12'hfec, 8'h00);
    $display("window test done");
    nrst <= 1'b0;
    @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    `CMP("pc", 15'h0000, pc)
    rchk(`PCS_OFF_INDEX, 8'h1f);
    $display("second reset test done");
    print_verdict();
  end
endmodule // test_pcs_top
